// File: logic/misv_pkg.sv
// misv_pkg: constants and carrier types for the monitored input status block
package misv_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int MISV_POINTS = 16; // input points per module
  localparam int MISV_AW = 8; // apb address width
  localparam int MISV_DW = 32; // apb data width

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] MISV_OFS_INPUT = 8'h00; // ro: packed switch states
  localparam logic [7:0] MISV_OFS_LINE = 8'h04; // ro: packed line-fault-ok states
  localparam logic [7:0] MISV_OFS_LMD = 8'h08; // rw: line monitor device fitted per point
  localparam logic [7:0] MISV_OFS_CTRL = 8'h0C; // rw/pulse: test enable, voted reset
  localparam logic [7:0] MISV_OFS_FAULT = 8'h10; // ro: module fault bit
  localparam logic [7:0] MISV_OFS_ISTAT = 8'h14; // ro: sticky event status
  localparam logic [7:0] MISV_OFS_ICLR = 8'h18; // wo: write one to clear status
  localparam logic [7:0] MISV_OFS_IEN = 8'h1C; // rw: event enable

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int MISV_CTRL_TEST_EN = 0; // ctrl: automatic test enable
  localparam int MISV_CTRL_VRESET = 1; // ctrl: voted reset pulse
  localparam int MISV_EV_FAULT = 0; // event: module fault raised
  localparam int MISV_EV_LINE = 1; // event: some line went faulty
  localparam int MISV_EVENTS = 2; // number of event bits
  localparam logic [15:0] MISV_LMD_RST = 16'h0000; // no monitor devices assumed
  localparam logic MISV_TEST_EN_RST = 1'b1; // self test runs from reset
  localparam int MISV_TEST_GAP = 1024; // cycles between test steps

  // ----------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------
  // comparator view of the field wiring, one bit per point, bit 0 is point one
  typedef struct packed {
    logic [15:0] current_on; // current above on/off threshold
    logic [15:0] wire_open; // current below open threshold
    logic [15:0] wire_short; // current above short threshold
  } misv_field_type;

  // self test sequencer states
  typedef enum logic [1:0] {
    MISV_ST_WAIT,
    MISV_ST_DRIVE,
    MISV_ST_CHECK
  } misv_state_type;

endpackage : misv_pkg

// File: logic/misv_top.sv
// misv_top: point status readout, line monitoring, self test and apb registers
//
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/1ps
// Notes on behaviour
// R1: switch closed, current flows, point reads one
// R2: fitted monitor and clean wiring give line ok
// R3: fault or missing monitor clears line ok
// R4: open wiring reads off, short reads on
// R5: self test failure sets module fault bit
// R6: controller: dual energized clears when both off
// R7: controller: energized vote follows healthy survivor
// R8: controller: dual de-energized sets when both on
// R9: controller: de-energized vote follows healthy survivor
// R10: voted reset clears module fault bit
// R11: controller: triple modules vote two of three
// R12: controller: alarm operators on any line fault
// R13: line faults unlatched, never set module fault
// R14: point one in bit zero, sixteen msb
// R15: controller: faulted module excluded until voted reset
module misv_top
  import misv_pkg::*;
#(
  parameter int TEST_GAP = MISV_TEST_GAP
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [MISV_AW-1:0] paddr,
  input wire logic [MISV_DW-1:0] pwdata,
  output logic [MISV_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // field comparators
  input wire misv_field_type field,
  input wire logic [15:0] test_echo,
  output logic [15:0] test_drive,
  // status to controller
  output logic [15:0] input_state,
  output logic [15:0] line_ok,
  output logic module_fault_bit,
  output logic irq
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [15:0] input_state_q; // packed switch states
  logic [15:0] line_ok_q; // packed line-fault-ok states
  logic [15:0] input_state_d; // decoded switch states
  logic [15:0] line_ok_d; // decoded line states
  logic [15:0] lmd_q; // monitor device fitted per point
  logic test_en_q; // automatic test enable
  logic fault_q; // module fault bit
  logic [MISV_EVENTS-1:0] istat_q; // sticky events
  logic [MISV_EVENTS-1:0] ien_q; // event enables
  logic [MISV_EVENTS-1:0] ev_set; // event pulses this cycle
  logic irq_q; // interrupt level
  logic [MISV_DW-1:0] prdata_q; // read data
  logic pready_q; // access phase answer
  logic pslverr_q; // unmapped access
  logic wr_en; // write takes effect
  logic vreset; // voted reset pulse
  logic mismatch; // self test failure seen
  misv_state_type state_q; // test sequencer
  logic [15:0] gap_q; // cycles to next test step
  logic [3:0] walk_q; // point under test
  logic [15:0] drive_q; // test pattern out

  // address is one of the mapped words
  function automatic logic misv_mapped(input logic [MISV_AW-1:0] a);
    misv_mapped = (a == MISV_OFS_INPUT) || (a == MISV_OFS_LINE) || (a == MISV_OFS_LMD) ||
                  (a == MISV_OFS_CTRL) || (a == MISV_OFS_FAULT) || (a == MISV_OFS_ISTAT) ||
                  (a == MISV_OFS_ICLR) || (a == MISV_OFS_IEN);
  endfunction : misv_mapped

  // ----------------------------------------------------------------
  // per point decode
  // ----------------------------------------------------------------
  for (genvar i = 0; i < MISV_POINTS; i++) begin : g_point
    // short forces on, open without short forces off, else the switch current
    assign input_state_d[i] = field.wire_short[i] |
                              (field.current_on[i] & ~field.wire_open[i]); // R1 R4
    // ok only with a fitted monitor and clean wiring
    assign line_ok_d[i] = lmd_q[i] & ~field.wire_open[i] & ~field.wire_short[i]; // R2 R3
  end

  // status words follow the field every cycle, nothing latched
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      input_state_q <= '0;
      line_ok_q <= '0;
    end else begin
      input_state_q <= input_state_d; // R14
      line_ok_q <= line_ok_d; // R13
    end
  end

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  assign wr_en = psel & penable & pready_q & pwrite;
  assign vreset = wr_en & (paddr == MISV_OFS_CTRL) & pwdata[MISV_CTRL_VRESET];

  // zero wait state: answer in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else begin
      pready_q <= psel & ~penable;
      pslverr_q <= psel & ~penable & ~misv_mapped(paddr);
      if (psel && !penable && !pwrite) begin
        // read data is captured during setup
        unique case (paddr)
          MISV_OFS_INPUT: prdata_q <= {16'h0000, input_state_q}; // R14
          MISV_OFS_LINE: prdata_q <= {16'h0000, line_ok_q};
          MISV_OFS_LMD: prdata_q <= {16'h0000, lmd_q};
          MISV_OFS_CTRL: prdata_q <= {31'h0, test_en_q};
          MISV_OFS_FAULT: prdata_q <= {31'h0, fault_q};
          MISV_OFS_ISTAT: prdata_q <= {30'h0, istat_q};
          MISV_OFS_IEN: prdata_q <= {30'h0, ien_q};
          default: prdata_q <= '0; // clear register and holes read zero
        endcase
      end else if (!psel) begin
        prdata_q <= '0;
      end
    end
  end

  // software writable configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lmd_q <= MISV_LMD_RST;
      test_en_q <= MISV_TEST_EN_RST;
      ien_q <= '0;
    end else if (wr_en) begin
      if (paddr == MISV_OFS_LMD) lmd_q <= pwdata[15:0];
      if (paddr == MISV_OFS_CTRL) test_en_q <= pwdata[MISV_CTRL_TEST_EN];
      if (paddr == MISV_OFS_IEN) ien_q <= pwdata[MISV_EVENTS-1:0];
    end
  end

  // ----------------------------------------------------------------
  // automatic self test
  // ----------------------------------------------------------------
  assign mismatch = (state_q == MISV_ST_CHECK) && (test_echo != drive_q);

  // walk a single test bit over the points, check the echo next cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= MISV_ST_WAIT;
      gap_q <= '0;
      walk_q <= '0;
      drive_q <= '0;
    end else begin
      unique case (state_q)
        MISV_ST_WAIT: begin
          drive_q <= '0;
          if (!test_en_q) begin
            gap_q <= '0; // hold off while disabled
          end else if (gap_q == 16'(TEST_GAP - 1)) begin
            gap_q <= '0;
            drive_q <= 16'h0001 << walk_q;
            state_q <= MISV_ST_DRIVE;
          end else begin
            gap_q <= gap_q + 16'h0001;
          end
        end
        MISV_ST_DRIVE: state_q <= MISV_ST_CHECK; // let the echo settle
        MISV_ST_CHECK: begin
          drive_q <= '0;
          walk_q <= walk_q + 4'h1;
          state_q <= MISV_ST_WAIT;
        end
      endcase
    end
  end

  // module fault: set by test failure only, cleared by voted reset, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_q <= 1'b0;
    end else if (mismatch) begin
      fault_q <= 1'b1; // R5
    end else if (vreset) begin
      fault_q <= 1'b0; // R10
    end
  end

  // ----------------------------------------------------------------
  // events and interrupt
  // ----------------------------------------------------------------
  assign ev_set[MISV_EV_FAULT] = mismatch & ~fault_q;
  assign ev_set[MISV_EV_LINE] = |(line_ok_q & ~line_ok_d);

  // sticky status, clear by write one, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      istat_q <= '0;
    end else if (wr_en && paddr == MISV_OFS_ICLR) begin
      istat_q <= (istat_q & ~pwdata[MISV_EVENTS-1:0]) | ev_set;
    end else begin
      istat_q <= istat_q | ev_set;
    end
  end

  // interrupt level from enabled status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) irq_q <= 1'b0;
    else irq_q <= |(istat_q & ien_q);
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign test_drive = drive_q;
  assign input_state = input_state_q;
  assign line_ok = line_ok_q;
  assign module_fault_bit = fault_q;
  assign irq = irq_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // every point: current without open reads on, no current without short reads off
  property p_closed_is_on;
    1'b1 |=> ((~input_state_q & $past(field.current_on) & ~$past(field.wire_open)) == 16'h0000)
         && ((input_state_q & ~$past(field.current_on) & ~$past(field.wire_short)) == 16'h0000);
  endproperty
  a_closed_is_on: assert property (p_closed_is_on) else $error("closed switch not on"); // R1

  // every fitted point with clean wiring shows line ok
  property p_line_ok_clean;
    1'b1 |=> (~line_ok_q & $past(lmd_q) & ~$past(field.wire_open) & ~$past(field.wire_short))
      == 16'h0000;
  endproperty
  a_line_ok_clean: assert property (p_line_ok_clean) else $error("clean line not ok"); // R2

  property p_line_bad;
    1'b1 |=> (line_ok_q & ($past(field.wire_open) | $past(field.wire_short) |
                           ~$past(lmd_q))) == 16'h0000;
  endproperty
  a_line_bad: assert property (p_line_bad) else $error("faulty line shows ok"); // R3

  property p_open_short;
    1'b1 |=> ((input_state_q & $past(field.wire_open) & ~$past(field.wire_short)) == 16'h0000)
         && ((~input_state_q & $past(field.wire_short)) == 16'h0000);
  endproperty
  a_open_short: assert property (p_open_short) else $error("open/short reading wrong"); // R4

  property p_test_fault;
    (state_q == MISV_ST_CHECK && test_echo != drive_q) |=> fault_q ##1 (fault_q || $past(vreset));
  endproperty
  a_test_fault: assert property (p_test_fault) else $error("test failure not flagged"); // R5

  property p_vreset_clear;
    (vreset && !mismatch) |=> !fault_q;
  endproperty
  a_vreset_clear: assert property (p_vreset_clear) else $error("voted reset kept fault"); // R10

  property p_no_line_fault_latch;
    $rose(fault_q) |-> $past(mismatch);
  endproperty
  a_no_line_fault_latch: assert property (p_no_line_fault_latch)
    else $error("fault raised without test failure"); // R13

  property p_pack_order;
    (psel && !penable && !pwrite && paddr == MISV_OFS_INPUT)
      |=> prdata_q == {16'h0000, $past(input_state_q)};
  endproperty
  a_pack_order: assert property (p_pack_order) else $error("input word packing wrong"); // R14

  c_fault_then_reset: cover property (mismatch ##[1:50] vreset);
  c_line_fault_irq: cover property (ev_set[MISV_EV_LINE] ##[1:4] irq_q);
  c_unmapped: cover property (pslverr_q && pready_q);

endmodule : misv_top

// File: verif/misv_voter.sv
// misv_voter: controller voting model fed by module readings and fault bits
`timescale 1ns/1ps
module misv_voter (
  // readings of modules a, b and c
  input wire logic input_from_module_a,
  input wire logic input_from_module_b,
  input wire logic input_from_module_c,
  // module fault bits of a and b
  input wire logic module_a_fault_bit,
  input wire logic module_b_fault_bit,
  // line-fault-ok word of module a
  input wire logic [15:0] line_ok,
  // voted results and operator alarm
  output logic vote_energized,
  output logic vote_deenergized,
  output logic voted_input_value,
  output logic line_alarm
);
  // --------------------------------------------------------------
  // voting
  // --------------------------------------------------------------
  // a faulted module drops out of the energized and de-energized votes until its bit clears, the two of three majority uses raw readings
  logic a_ok;
  logic b_ok;
  assign a_ok = !module_a_fault_bit;
  assign b_ok = !module_b_fault_bit;
  // off only when both healthy readings are off, survivor rules alone
  assign vote_energized = (input_from_module_a && a_ok) || (input_from_module_b && b_ok);
  // on only when both healthy readings are on, survivor rules alone
  assign vote_deenergized = (input_from_module_a || !a_ok) && (input_from_module_b || !b_ok);
  // two of three majority
  assign voted_input_value = (input_from_module_a && input_from_module_b) ||
    (input_from_module_a && input_from_module_c) || (input_from_module_b && input_from_module_c);
  // any line fault reported raises the alarm
  assign line_alarm = (line_ok !== 16'hFFFF);
endmodule : misv_voter

// File: verif/tb_misv_top.sv
// tb_misv_top: self-checking bench for the monitored input status block
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin error_cnt++; \
  $display("wrong value at %0t: got %h exp %h", $time, a, e); end end
module tb_misv_top;
  import misv_pkg::*;
  // --------------------------------------------------------------
  // signals
  // --------------------------------------------------------------
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, mfb, irq, bad = 0, b_in = 0, c_in = 0;
  misv_field_type field = '0;
  logic [15:0] test_echo, test_drive, input_state, line_ok;
  logic v_en, v_de, v_tri, alarm;
  int error_cnt = 0, checks_done = 0;
  // healthy echo, or inverted when a broken module is wanted
  assign test_echo = test_drive ^ {16{bad}};
  initial forever #10 pclk = ~pclk;
  misv_top #(.TEST_GAP(4)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .field(field), .test_echo(test_echo),
    .test_drive(test_drive), .input_state(input_state), .line_ok(line_ok),
    .module_fault_bit(mfb), .irq(irq));
  misv_voter i_voter (.input_from_module_a(input_state[0]), .input_from_module_b(b_in),
    .input_from_module_c(c_in), .module_a_fault_bit(mfb), .module_b_fault_bit(1'b0),
    .line_ok(line_ok), .vote_energized(v_en), .vote_deenergized(v_de),
    .voted_input_value(v_tri), .line_alarm(alarm));
  // --------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------
  // verdict and end of run
  task results();
    $display("mismatches %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : results
  // one apb transfer, held until pready is sampled
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    if (pready !== 1'b1) begin error_cnt++; results(); end
  endtask : apb
  // table of field conditions, point packing, line faults unlatched
  task t_field();
    apb(1, MISV_OFS_LMD, 32'h7FFF);
    apb(1, MISV_OFS_IEN, 32'h2);
    @(posedge pclk);
    field.current_on <= 16'h8005;
    field.wire_open <= 16'h0004;
    field.wire_short <= 16'h0008;
    repeat (3) @(posedge pclk);
    `CHK(input_state, 16'h8009)
    `CHK(line_ok, 16'h7FF3)
    `CHK(alarm, 1'b1)
    apb(0, MISV_OFS_INPUT, 0);
    `CHK(rd, 32'h8009)
    apb(0, MISV_OFS_LINE, 0);
    `CHK(rd, 32'h7FF3)
    `CHK(irq, 1'b1)
    `CHK(mfb, 1'b0)
    field.wire_open <= 16'h0;
    field.wire_short <= 16'h0;
    repeat (3) @(posedge pclk);
    `CHK(line_ok, 16'h7FFF)
    `CHK(input_state, 16'h8005)
    apb(1, MISV_OFS_ICLR, 32'h2);
    repeat (2) @(posedge pclk);
    `CHK(irq, 1'b0)
    apb(1, MISV_OFS_LMD, 32'hFFFF);
    repeat (2) @(posedge pclk);
    `CHK(line_ok, 16'hFFFF)
    `CHK(alarm, 1'b0)
    apb(0, 8'h20, 0);
    `CHK({err, rd}, 33'h1_0000_0000)
  endtask : t_field
  // self test fault, survivor voting, voted reset
  task t_selftest();
    int n;
    apb(0, MISV_OFS_CTRL, 0);
    `CHK(rd, 32'h1)
    `CHK({v_en, v_de, v_tri}, 3'b100)
    n = 0;
    do begin @(posedge pclk); n++; end while (test_drive == 16'h0000 && n < 20);
    `CHK({test_drive != 16'h0000, test_drive & (test_drive - 16'h0001)}, 17'h1_0000)
    bad <= 1;
    n = 0;
    do begin @(posedge pclk); n++; end while (mfb !== 1'b1 && n < 40);
    `CHK(mfb, 1'b1)
    if (mfb !== 1'b1) results();
    `CHK(v_en, 1'b0)
    `CHK(v_de, 1'b0)
    c_in <= 1;
    @(posedge pclk);
    `CHK(v_tri, 1'b1)
    c_in <= 0;
    b_in <= 1;
    @(posedge pclk);
    `CHK(v_en, 1'b1)
    `CHK(v_de, 1'b1)
    `CHK(v_tri, 1'b1)
    apb(0, MISV_OFS_ISTAT, 0);
    `CHK(rd[0], 1'b1)
    bad <= 0;
    apb(1, MISV_OFS_CTRL, 32'h3);
    repeat (2) @(posedge pclk);
    `CHK(mfb, 1'b0)
    `CHK(v_de, 1'b1)
    apb(0, MISV_OFS_FAULT, 0);
    `CHK(rd, 32'h0)
  endtask : t_selftest
  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1;
    t_field();
    t_selftest();
    results();
  end
endmodule : tb_misv_top
